// ==== grf_pkg.sv ====
package grf_pkg;
   localparam logic [7:0] ADDR_DATA_LO = 8'h12;
   localparam logic [7:0] ADDR_DATA_HI = 8'h13;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h1D;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h1E;
   localparam logic [7:0] ADDR_LEN_LO = 8'h22;
   localparam logic [7:0] ADDR_LEN_HI = 8'h23;
   localparam logic [7:0] ADDR_RANGE = 8'h43;
   localparam logic [7:0] ADDR_DOWNS = 8'h45;
   localparam logic [7:0] ADDR_SETUP0 = 8'h46;
   localparam logic [7:0] ADDR_SETUP1 = 8'h47;
   localparam logic [2:0] RST_RANGE = 3'h0;
   localparam logic [3:0] RST_DOWNS = 4'h0;
   localparam logic [7:0] RST_SETUP0 = 8'h80;
   localparam logic [7:0] RST_SETUP1 = 8'h10;
   localparam logic [2:0] RANGE_MAX_CODE = 3'h4;
   localparam int BIT_FILT = 3;
   localparam int BIT_GYR_EN = 7;
   localparam int BIT_HDR_EN = 4;
   localparam int BIT_TAG1 = 3;
   localparam int BIT_TAG2 = 2;
   localparam int BIT_TIME_EN = 1;
   localparam int BIT_STOP_FULL = 0;
   localparam logic [7:0] SETUP1_MASK = 8'h9F;
   localparam int STAT_DRDY = 0;
   localparam int STAT_FWM = 1;
   localparam int STAT_FFULL = 2;
   localparam logic [10:0] FIFO_BYTES = 11'h400;
   localparam logic [10:0] FRAME_BODY = 11'h006;
   localparam logic [10:0] FRAME_HDR = 11'h001;
   localparam logic [1:0] WM_UNIT_SHIFT = 2'h2;
endpackage : grf_pkg

// ==== grf_top.sv ====
// The address-and-strobe port is this design's own decision.
module grf_top (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic sample_valid,
   input wire logic signed [15:0] raw_sample,
   input wire logic signed [15:0] filt_sample,
   input wire logic irq_pin_one,
   input wire logic irq_pin_two,
   input wire logic frame_popped,
   input wire logic read_past_end,
   output logic fifo_wr_valid,
   output logic [15:0] fifo_wr_data,
   output logic fifo_wr_hdr,
   output logic [1:0] fifo_wr_tag,
   output logic time_frame,
   output logic fifo_full,
   output logic irq
);

   typedef struct packed {
      logic [2:0] range;
      logic [3:0] downs;
      logic [7:0] setup0;
      logic [7:0] setup1;
      logic [10:0] count;
      logic [6:0] dec_cnt;
      logic [2:0] stat;
      logic [2:0] en;
      logic wm_hit;
      logic [15:0] data;
      logic [7:0] rdata;
      logic wr_valid;
      logic [15:0] wr_data;
      logic wr_hdr;
      logic [1:0] wr_tag;
      logic time_frame;
      logic full;
      logic irq;
   } grf_state_t;

   grf_state_t s_q;
   grf_state_t s_d;

   // Sensitivity of 16.4 counts per deg/s doubled per range step, saturated
   function automatic logic [15:0] grf_scale(input logic signed [15:0] v,
                                             input logic [2:0] code);
      logic signed [19:0] wide;
      logic [2:0] sh;
      sh = (code > grf_pkg::RANGE_MAX_CODE) ? 3'h0 : code;
      wide = 20'(v) <<< sh;
      if (wide > 20'sh07FFF) begin
         grf_scale = 16'h7FFF;
      end else if (wide < -20'sh08000) begin
         grf_scale = 16'h8000;
      end else begin
         grf_scale = wide[15:0];
      end
   endfunction

   function automatic logic grf_wm_over(input logic [10:0] cnt, input logic [7:0] wm);
      grf_wm_over = cnt > (11'(wm) << grf_pkg::WM_UNIT_SHIFT);
   endfunction

   logic [6:0] dec_mask;
   logic take;
   logic [10:0] frame_len;
   logic [10:0] add_len;
   logic [11:0] sum;
   logic room;
   logic [15:0] pick;
   logic [2:0] ev;

   always_comb begin
      s_d = s_q;
      dec_mask = 7'((8'h01 << s_q.downs[2:0]) - 8'h01);
      pick = s_q.downs[grf_pkg::BIT_FILT] ? filt_sample : raw_sample;
      frame_len = grf_pkg::FRAME_BODY;
      if (s_q.setup1[grf_pkg::BIT_HDR_EN]) begin
         frame_len = grf_pkg::FRAME_BODY + grf_pkg::FRAME_HDR;
      end
      sum = {1'b0, s_q.count} + {1'b0, frame_len};
      room = sum <= {1'b0, grf_pkg::FIFO_BYTES};
      take = sample_valid && ((s_q.dec_cnt & dec_mask) == 7'h00)
             && s_q.setup1[grf_pkg::BIT_GYR_EN]
             && (room || !s_q.setup1[grf_pkg::BIT_STOP_FULL]);
      add_len = take ? frame_len : 11'h000;
      ev = 3'h0;

      if (sample_valid) begin
         s_d.dec_cnt = 7'((s_q.dec_cnt + 7'h01) & dec_mask);
         s_d.data = grf_scale(raw_sample, s_q.range);
      end

      // Fill level moves only on whole frames
      if (take || frame_popped) begin
         if (frame_popped && s_q.count >= frame_len) begin
            s_d.count = s_q.count + add_len - frame_len;
         end else if (sum > 12'h7FF && take) begin
            s_d.count = 11'h7FF;
         end else begin
            s_d.count = s_q.count + add_len;
         end
         s_d.wm_hit = grf_wm_over(s_d.count, s_q.setup0);
         ev[grf_pkg::STAT_FWM] = s_d.wm_hit && !s_q.wm_hit;
      end
      s_d.full = s_d.count >= grf_pkg::FIFO_BYTES;
      ev[grf_pkg::STAT_FFULL] = s_d.full && !s_q.full;
      ev[grf_pkg::STAT_DRDY] = sample_valid;

      s_d.wr_valid = take;
      s_d.wr_data = take ? pick : s_q.wr_data;
      s_d.wr_hdr = take && s_q.setup1[grf_pkg::BIT_HDR_EN];
      s_d.wr_tag = take ? {irq_pin_two && s_q.setup1[grf_pkg::BIT_TAG2],
                           irq_pin_one && s_q.setup1[grf_pkg::BIT_TAG1]} : 2'h0;
      s_d.time_frame = read_past_end && s_q.setup1[grf_pkg::BIT_TIME_EN];

      // Register writes; a range write does not touch the status flags
      if (reg_wr) begin
         case (reg_addr)
            grf_pkg::ADDR_RANGE: s_d.range = reg_wdata[2:0];
            grf_pkg::ADDR_DOWNS: s_d.downs = reg_wdata[3:0];
            grf_pkg::ADDR_SETUP0: s_d.setup0 = reg_wdata;
            grf_pkg::ADDR_SETUP1: s_d.setup1 = reg_wdata & grf_pkg::SETUP1_MASK;
            grf_pkg::ADDR_IRQ_CLR: s_d.stat = s_q.stat & ~reg_wdata[2:0];
            grf_pkg::ADDR_IRQ_EN: s_d.en = reg_wdata[2:0];
            default: ;
         endcase
      end

      // Reading the low rate-data byte retires a stale data-ready flag
      if (reg_rd && reg_addr == grf_pkg::ADDR_DATA_LO) begin
         s_d.stat[grf_pkg::STAT_DRDY] = 1'b0;
      end
      s_d.stat = s_d.stat | ev;

      s_d.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            grf_pkg::ADDR_DATA_LO: s_d.rdata = s_q.data[7:0];
            grf_pkg::ADDR_DATA_HI: s_d.rdata = s_q.data[15:8];
            grf_pkg::ADDR_IRQ_STAT: s_d.rdata = {5'h00, s_q.stat};
            grf_pkg::ADDR_IRQ_EN: s_d.rdata = {5'h00, s_q.en};
            grf_pkg::ADDR_LEN_LO: s_d.rdata = s_q.count[7:0];
            grf_pkg::ADDR_LEN_HI: s_d.rdata = {5'h00, s_q.count[10:8]};
            grf_pkg::ADDR_RANGE: s_d.rdata = {5'h00, s_q.range};
            grf_pkg::ADDR_DOWNS: s_d.rdata = {4'h0, s_q.downs};
            grf_pkg::ADDR_SETUP0: s_d.rdata = s_q.setup0;
            grf_pkg::ADDR_SETUP1: s_d.rdata = s_q.setup1;
            default: s_d.rdata = 8'h00;
         endcase
      end
      s_d.irq = |(s_d.stat & s_d.en);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q <= '0;
         s_q.range <= grf_pkg::RST_RANGE;
         s_q.downs <= grf_pkg::RST_DOWNS;
         s_q.setup0 <= grf_pkg::RST_SETUP0;
         s_q.setup1 <= grf_pkg::RST_SETUP1;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata = s_q.rdata;
   assign fifo_wr_valid = s_q.wr_valid;
   assign fifo_wr_data = s_q.wr_data;
   assign fifo_wr_hdr = s_q.wr_hdr;
   assign fifo_wr_tag = s_q.wr_tag;
   assign time_frame = s_q.time_frame;
   assign fifo_full = s_q.full;
   assign irq = s_q.irq;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   chk_range_readback: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_RANGE ##1 reg_rd && reg_addr == grf_pkg::ADDR_RANGE
      |=> reg_rdata == {5'h00, $past(reg_wdata[2:0], 2)})
      else $error("range readback wrong");

   chk_scale_top: assert property (
      sample_valid && s_q.range == 3'h4 && raw_sample == 16'sh0010
      |=> s_q.data == 16'h0100)
      else $error("range scaling wrong");

   chk_drdy_kept: assert property (
      s_q.stat[grf_pkg::STAT_DRDY] && reg_wr && reg_addr == grf_pkg::ADDR_RANGE
      && !(reg_rd && reg_addr == grf_pkg::ADDR_DATA_LO)
      |=> s_q.stat[grf_pkg::STAT_DRDY])
      else $error("range write cleared data ready");

   chk_decim_skip: assert property (
      sample_valid && (s_q.dec_cnt & dec_mask) != 7'h00 |=> !fifo_wr_valid)
      else $error("decimated sample entered");

   chk_filt_pick: assert property (
      sample_valid && fifo_wr_valid == 1'b0 ##0 (s_d.wr_valid)
      |=> fifo_wr_data == ($past(s_q.downs[3]) ? $past(filt_sample) : $past(raw_sample)))
      else $error("wrong sample source");

   chk_wm_level: assert property (
      $changed(s_q.count) && !$changed(s_q.setup0)
      |-> s_q.wm_hit == (s_q.count > {1'b0, s_q.setup0, 2'b00}))
      else $error("watermark compare wrong");

   chk_wm_event: assert property (
      $rose(s_q.wm_hit) |-> s_q.stat[grf_pkg::STAT_FWM])
      else $error("watermark event lost");

   chk_gyr_gate: assert property (
      !s_q.setup1[grf_pkg::BIT_GYR_EN] |=> !fifo_wr_valid && !fifo_wr_hdr)
      else $error("write while gyro disabled");

   chk_hdr_mode: assert property (
      fifo_wr_valid |-> fifo_wr_hdr == $past(s_q.setup1[grf_pkg::BIT_HDR_EN]))
      else $error("header flag mismatch");

   chk_stop_full: assert property (
      s_q.setup1[grf_pkg::BIT_STOP_FULL] && s_q.count >= grf_pkg::FIFO_BYTES
      |=> !fifo_wr_valid)
      else $error("write while full");

   chk_count_step: assert property (
      !$past(s_d.wr_valid) && !$past(frame_popped) |-> $stable(s_q.count))
      else $error("count moved without frame");

   chk_time_frame: assert property (
      read_past_end |=> time_frame == $past(s_q.setup1[grf_pkg::BIT_TIME_EN]))
      else $error("sensortime frame wrong");

   chk_tag_pins: assert property (
      s_d.wr_valid && irq_pin_one && !s_q.setup1[grf_pkg::BIT_TAG1] |=> !fifo_wr_tag[0])
      else $error("tag without enable");

   chk_rdata_idle: assert property (
      !reg_rd
      |=> reg_rdata == 8'h00)
      else $error("read data outside read cycle");

   chk_setup0_store: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_SETUP0
      |=> s_q.setup0 == $past(reg_wdata))
      else $error("watermark byte not stored");

   chk_setup1_store: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_SETUP1
      |=> s_q.setup1 == ($past(reg_wdata) & grf_pkg::SETUP1_MASK))
      else $error("mode byte not stored");

   chk_range_store: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_RANGE
      |=> s_q.range == $past(reg_wdata[2:0]))
      else $error("range code not stored");

   chk_downs_store: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_DOWNS
      |=> s_q.downs == $past(reg_wdata[3:0]))
      else $error("decimation byte not stored");

   chk_scale_one: assert property (
      sample_valid && s_q.range == 3'h1 && raw_sample > 16'sh0000 && raw_sample < 16'sh0400
      |=> s_q.data == 16'($past(raw_sample) * 2))
      else $error("sensitivity not doubled");

   chk_scale_rsvd: assert property (
      sample_valid && s_q.range > grf_pkg::RANGE_MAX_CODE
      |=> s_q.data == $past(raw_sample))
      else $error("reserved range scaled");

   chk_tag_idle: assert property (
      !fifo_wr_valid
      |-> fifo_wr_tag == 2'h0)
      else $error("tag without frame");

   chk_hdr_alone: assert property (
      fifo_wr_hdr
      |-> fifo_wr_valid)
      else $error("header without frame");

   chk_decim_take: assert property (
      sample_valid && (s_q.dec_cnt & dec_mask) == 7'h00 && s_q.setup1[grf_pkg::BIT_GYR_EN]
      && !s_q.setup1[grf_pkg::BIT_STOP_FULL] |=> fifo_wr_valid)
      else $error("kept sample dropped");

   chk_count_add: assert property (
      take && !frame_popped && !(sum > 12'h7FF)
      |=> s_q.count == $past(s_q.count) + $past(frame_len))
      else $error("count not raised by frame");

   chk_count_pop: assert property (
      frame_popped && !take && s_q.count >= frame_len
      |=> s_q.count == $past(s_q.count) - $past(frame_len))
      else $error("count not lowered by frame");

   chk_count_sat: assert property (
      take && !frame_popped && sum > 12'h7FF
      |=> s_q.count == 11'h7FF)
      else $error("count not saturated");

   chk_full_flag: assert property (
      fifo_full == (s_q.count >= grf_pkg::FIFO_BYTES))
      else $error("full flag wrong");

   chk_irq_level: assert property (
      irq == |(s_q.stat & s_q.en))
      else $error("interrupt level wrong");

   chk_en_store: assert property (
      reg_wr && reg_addr == grf_pkg::ADDR_IRQ_EN
      |=> s_q.en == $past(reg_wdata[2:0]))
      else $error("enable not stored");

   chk_drdy_set: assert property (
      sample_valid
      |=> s_q.stat[grf_pkg::STAT_DRDY])
      else $error("data ready not set");

   chk_drdy_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_DATA_LO && !sample_valid
      |=> !s_q.stat[grf_pkg::STAT_DRDY])
      else $error("data ready not retired");

   chk_time_idle: assert property (
      !read_past_end
      |=> !time_frame)
      else $error("sensortime frame without over-read");

   chk_wm_hold: assert property (
      !take && !frame_popped
      |=> $stable(s_q.wm_hit))
      else $error("watermark moved without frame");

   chk_downs_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_DOWNS
      |=> reg_rdata == {4'h0, $past(s_q.downs)})
      else $error("decimation readback wrong");

   chk_setup0_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_SETUP0
      |=> reg_rdata == $past(s_q.setup0))
      else $error("watermark readback wrong");

   chk_setup1_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_SETUP1
      |=> reg_rdata[6:5] == 2'b00)
      else $error("reserved mode bits set");

   chk_range_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_RANGE
      |=> reg_rdata[7:3] == 5'h00)
      else $error("reserved range bits set");

   chk_len_read: assert property (
      reg_rd && reg_addr == grf_pkg::ADDR_LEN_LO
      |=> reg_rdata == $past(s_q.count[7:0]))
      else $error("fill level readback wrong");

   chk_tag_one: assert property (
      take && irq_pin_one && s_q.setup1[grf_pkg::BIT_TAG1]
      |=> fifo_wr_tag[0])
      else $error("pin one tag lost");

   chk_tag_two: assert property (
      take && irq_pin_two && s_q.setup1[grf_pkg::BIT_TAG2]
      |=> fifo_wr_tag[1])
      else $error("pin two tag lost");

   chk_hdr_on: assert property (
      take && s_q.setup1[grf_pkg::BIT_HDR_EN]
      |=> fifo_wr_hdr)
      else $error("header missing");

   chk_valid_pulse: assert property (
      fifo_wr_valid
      |-> $past(sample_valid))
      else $error("frame without sample");

   chk_data_hold: assert property (
      !take
      |=> $stable(fifo_wr_data))
      else $error("frame data moved");

endmodule // grf_top

// ==== grf_fifo_model.sv ====
module grf_fifo_model #(
   parameter int DELAY = 3
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic fifo_wr_valid,
   output logic frame_popped
);
   timeunit 1ns;
   timeprecision 1ps;
   int pending;
   int wait_cnt;
   logic pop;
   assign pop = (pending > 0) && (wait_cnt >= DELAY);
   // Reads whole frames only, one every DELAY+1 cycles while frames wait
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pending <= 0;
         wait_cnt <= 0;
         frame_popped <= 1'b0;
      end else begin
         pending <= pending + int'(fifo_wr_valid) - int'(pop);
         wait_cnt <= (pop || pending == 0) ? 0 : wait_cnt + 1;
         frame_popped <= pop;
      end
   end
endmodule // grf_fifo_model

// ==== tb_top.sv ====
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset_n, reg_wr, reg_rd, sample_valid, p1, p2, read_past_end, rd_pend;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic signed [15:0] rs, fs;
   logic fifo_wr_valid, fifo_wr_hdr, time_frame, fifo_full, irq, frame_popped;
   logic [15:0] fifo_wr_data;
   logic [1:0] fifo_wr_tag;
   logic [7:0] rq[$];
   logic [18:0] fq[$];
   int n_errors, comparisons, n_frames, n_time;
   logic [2:0] b;
   grf_top u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_valid(sample_valid),
      .raw_sample(rs), .filt_sample(fs), .irq_pin_one(p1), .irq_pin_two(p2),
      .frame_popped(frame_popped), .read_past_end(read_past_end),
      .fifo_wr_valid(fifo_wr_valid), .fifo_wr_data(fifo_wr_data), .fifo_wr_hdr(fifo_wr_hdr),
      .fifo_wr_tag(fifo_wr_tag), .time_frame(time_frame), .fifo_full(fifo_full), .irq(irq));
   grf_fifo_model #(.DELAY(3)) u_far (.clk(clk), .reset_n(reset_n),
      .fifo_wr_valid(fifo_wr_valid), .frame_popped(frame_popped));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
      reg_wr <= w;
      reg_rd <= r;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] e);
      rq.push_back(e);
      bus(1'b0, 1'b1, a, 8'h00);
   endtask
   task automatic idle(int k);
      repeat (k) bus(1'b0, 1'b0, 8'h00, 8'h00);
   endtask
   task automatic smp(int k);
      repeat (k) begin
         sample_valid <= 1'b1;
         idle(1);
         sample_valid <= 1'b0;
         idle(1);
      end
   endtask
   task automatic pulse_over_read();
      read_past_end <= 1'b1;
      idle(1);
      read_past_end <= 1'b0;
      idle(3);
   endtask
   always @(posedge clk) begin
      if (rd_pend) check("reg_rdata", reg_rdata, rq.pop_front());
      rd_pend <= reg_rd;
      if (fifo_wr_valid) begin
         n_frames++;
         check("frame", {fifo_wr_hdr, fifo_wr_tag, fifo_wr_data}, fq.pop_front());
      end
      if (time_frame) n_time++;
   end
   initial begin
      #100000;
      n_errors++;
      final_report();
   end
   initial begin
      {reg_wr, reg_rd, sample_valid, p1, p2, read_past_end} = '0;
      {reg_addr, reg_wdata, rs, fs} = '0;
      reset_n = 1'b0;
      void'($urandom(32'h3B59B7F9));
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rd(8'h43, 8'h00);
      rd(8'h45, 8'h00);
      rd(8'h46, 8'h80);
      rd(8'h47, 8'h10);
      rd(8'h00, 8'h00);
      rd(8'h1C, 8'h00);
      idle(2);
      $display("test 1 done");
      wr(8'h47, 8'hFF);
      rd(8'h47, 8'h9F);
      wr(8'h46, 8'hAB);
      rd(8'h46, 8'hAB);
      wr(8'h43, 8'h04);
      rd(8'h43, 8'h04);
      wr(8'h45, 8'hF5);
      rd(8'h45, 8'h05);
      idle(2);
      $display("test 2 done");
      for (int n = 0; n < 4; n++) begin
         b = 3'($urandom);
         p1 <= 1'($urandom);
         p2 <= 1'($urandom);
         rs <= 16'($urandom);
         fs <= 16'($urandom);
         wr(8'h45, {4'h0, b[0], 3'(n)});
         wr(8'h47, {3'b100, b[1], b[2], ~b[2], 2'b00});
         repeat (2) fq.push_back({b[1], ~b[2] & p2, b[2] & p1, b[0] ? fs : rs});
         smp(2 << n);
      end
      idle(30);
      check("frames", n_frames, 8);
      wr(8'h47, 8'h10);
      smp(4);
      idle(4);
      check("frames", n_frames, 8);
      $display("test 3 done");
      rs <= 16'($urandom_range(1000, 1));
      wr(8'h45, 8'h00);
      wr(8'h46, 8'h01);
      wr(8'h1E, 8'h02);
      wr(8'h1D, 8'h07);
      wr(8'h43, 8'h01);
      wr(8'h47, 8'h80);
      fq.push_back({3'b000, rs});
      smp(1);
      idle(2);
      check("irq", irq, 1);
      rd(8'h1C, 8'h03);
      wr(8'h1D, 8'h02);
      wr(8'h43, 8'h01);
      rd(8'h1C, 8'h01);
      rd(8'h12, 8'(rs << 1));
      rd(8'h1C, 8'h00);
      idle(2);
      check("irq", irq, 0);
      $display("test 4 done");
      wr(8'h47, 8'h10);
      wr(8'h43, 8'h04);
      rs <= 16'h0010;
      smp(1);
      rd(8'h13, 8'h01);
      rd(8'h12, 8'h00);
      check("fifo_full", fifo_full, 0);
      wr(8'h47, 8'h82);
      pulse_over_read();
      wr(8'h47, 8'h80);
      pulse_over_read();
      check("time_frame", n_time, 1);
      check("queues", rq.size() + fq.size(), 0);
      $display("test 5 done");
      final_report();
   end
endmodule // tb_top
